// *** design/gat_params.svh ***
// How it works
// [R1] Two independent alarm channels, low and high, each with set-point and direction.
// [R2] Both channels and settings exist whether or not relays are fitted.
// [R3] Every set-point is clamped to at most 60% of full scale.
// [R4] Factory reset loads low set-point 10% and high set-point 15% of full scale.
// [R5] Operator keeps low set-point at or below high; device does not enforce it.
// [R6] Each channel may activate on rising or on falling concentration.
// [R7] Oxygen default: low alarm falling, high alarm rising.
// [R8] Other gases default: both channels rising.
// [R9] Low indicator (amber) asserts when reading is at or above low set-point.
// [R10] High indicator (red) asserts when reading is at or above high set-point.
// [R11] Non-latching alarm releases once reading drops 10% below its set-point.
// [R12] Relay one follows low alarm, relay two follows high alarm, when fitted.
// [R13] After menu exit all alarm activation is held off for about one minute.
// [R14] Set-point screen: increment raises, decrement lowers, settings key stores and advances.
// [R15] Direction screen: increment picks rising, decrement falling, settings key stores.
// [R16] Menu order: low sp, low dir, high sp, high dir, then radio or normal.
// [R17] Radio address is settable from 1 to 255, default 1.
// [R18] Radio screen: keys adjust address; settings key stores and leaves menu.
// [R19] Latching alarm with indicator and relay stays on until manual reset.
// [R20] One settings press clears latched alarms only if reading is below set-point; a falling channel here clears only if reading is above it.
// [R21] Further settings presses after the latch reset open the menu.
// [R22] Holding decrement about 6 seconds turns the unit off; off shown while powered.
// [R23] One increment press while off restarts through the warm-up sequence.
// [R24] Falling alarm activates at or below set-point, releases 10% above it.
// [R25] Each channel has a latching setting choosing auto release or manual reset.
`ifndef GAT_PARAMS_SVH
`define GAT_PARAMS_SVH

`define GAT_CLK_HZ 200000000
`define GAT_FS 16'h03E8
`define GAT_SP_MAX_PCT 60
`define GAT_LOW_DEF_PCT 10
`define GAT_HIGH_DEF_PCT 15
`define GAT_BAND_PCT 10
`define GAT_HOLDOFF_S 60
`define GAT_WARMUP_S 60
`define GAT_OFF_HOLD_S 6
`define GAT_ADDR_MIN 8'h01
`define GAT_ADDR_MAX 8'hFF
`define GAT_ADDR_DEF 8'h01

// AXI-Lite byte offsets.
`define GAT_REG_CTRL 8'h00
`define GAT_REG_LOW_SP 8'h04
`define GAT_REG_HIGH_SP 8'h08
`define GAT_REG_STATUS 8'h0C
`define GAT_REG_ADDR 8'h10
`define GAT_REG_READING 8'h14

// Control register fields.
`define GAT_CTRL_LOW_LATCH 0
`define GAT_CTRL_HIGH_LATCH 1
`define GAT_CTRL_LOW_DIR 2
`define GAT_CTRL_HIGH_DIR 3
`define GAT_CTRL_FACTORY 4

`define GAT_RESP_OKAY 2'h0
`define GAT_RESP_SLVERR 2'h2

`endif

// *** design/gat_pkg.sv ***
package gat_pkg;
   typedef enum logic [6:0] {
      GAT_WARMUP = 7'h01,
      GAT_NORMAL = 7'h02,
      GAT_LOW_SP = 7'h04,
      GAT_LOW_DIR = 7'h08,
      GAT_HIGH_SP = 7'h10,
      GAT_HIGH_DIR = 7'h20,
      GAT_RADIO = 7'h40
   } gat_state_t;

   typedef struct packed {
      logic inc;
      logic dec;
      logic set;
   } gat_keys_t;

   typedef struct packed {
      logic [15:0] sp;
      logic rising;
      logic latching;
   } gat_chan_cfg_t;
endpackage

// *** design/gat_alarm.sv ***
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`include "gat_params.svh"

module gat_alarm
   import gat_pkg::*;
#(
   parameter longint unsigned HOLDOFF_CYC = 64'(`GAT_HOLDOFF_S) * `GAT_CLK_HZ,
   parameter longint unsigned WARMUP_CYC = 64'(`GAT_WARMUP_S) * `GAT_CLK_HZ,
   parameter int unsigned OFF_HOLD_CYC = `GAT_OFF_HOLD_S * `GAT_CLK_HZ,
   parameter bit OXYGEN = 1'b0,
   parameter bit RADIO_FITTED = 1'b1,
   parameter bit RELAYS_FITTED = 1'b1
) (
   // Clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // Sensor reading and front-panel keys (asynchronous)
   input wire logic [15:0] reading,
   input wire gat_keys_t keys,
   // Alarm, status and radio address outputs
   output logic led_low,
   output logic led_high,
   output logic relay_low,
   output logic relay_high,
   output logic unit_off,
   output logic in_menu,
   output logic warming,
   output logic [7:0] radio_addr,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam logic [15:0] SP_MAX = 16'((32'(`GAT_FS) * `GAT_SP_MAX_PCT) / 100); // R3
   localparam logic [15:0] LOW_DEF = 16'((32'(`GAT_FS) * `GAT_LOW_DEF_PCT) / 100);
   localparam logic [15:0] HIGH_DEF = 16'((32'(`GAT_FS) * `GAT_HIGH_DEF_PCT) / 100);
   localparam logic LOW_DIR_DEF = !OXYGEN;

   // Reading and keys come from outside; two flops each before use.
   logic [15:0] rd_s1, rd_s2;
   gat_keys_t k_s1, k_s2, k_prev;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_s1 <= 16'h0000;
         rd_s2 <= 16'h0000;
         k_s1 <= '0;
         k_s2 <= '0;
         k_prev <= '0;
      end else if (clk_en) begin
         rd_s1 <= reading;
         rd_s2 <= rd_s1;
         k_s1 <= keys;
         k_s2 <= k_s1;
         k_prev <= k_s2;
      end
   end
   wire press_inc = k_s2.inc & ~k_prev.inc;
   wire press_dec = k_s2.dec & ~k_prev.dec;
   wire press_set = k_s2.set & ~k_prev.set;

   gat_state_t state;
   gat_chan_cfg_t cfg [2];
   // A full minute of cycles at this clock needs 34 bits; 32 would wrap.
   logic [33:0] timer;
   logic [31:0] off_cnt;
   wire [1:0] alarm;
   logic latch_cleared;
   logic factory_req;

   // AXI-Lite write channel captures.
   logic aw_full, w_full;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   wire wr_go = aw_full & w_full & ~s_axi_bvalid;
   wire menu_idle = (state == GAT_NORMAL) | (state == GAT_WARMUP);

   function automatic logic [15:0] clamp_sp(input logic [15:0] v);
      clamp_sp = (v > SP_MAX) ? SP_MAX : v; // R3
   endfunction

   // Key-driven menu and off control.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= GAT_WARMUP;
         timer <= 34'h0;
         off_cnt <= 32'h0;
         unit_off <= 1'b0;
         latch_cleared <= 1'b0;
      end else if (clk_en) begin
         if (timer != 34'h0) begin
            timer <= timer - 34'h1;
         end
         if (unit_off) begin
            if (press_inc) begin // R23
               unit_off <= 1'b0;
               state <= GAT_WARMUP;
               timer <= 34'(WARMUP_CYC);
            end
         end else if (k_s2.dec && state == GAT_NORMAL && off_cnt >= OFF_HOLD_CYC - 1) begin
            unit_off <= 1'b1; // R22
            off_cnt <= 32'h0;
         end else begin
            off_cnt <= (k_s2.dec && state == GAT_NORMAL) ? off_cnt + 32'h1 : 32'h0;
            case (state)
               GAT_WARMUP: begin
                  if (timer <= 34'h1) begin
                     state <= GAT_NORMAL;
                  end
               end
               GAT_NORMAL: begin
                  if (!k_s2.set) begin
                     latch_cleared <= latch_cleared & (|alarm_latched_any());
                  end
                  if (press_set) begin
                     if (alarm_latched_any() && !latch_cleared) begin
                        latch_cleared <= 1'b1; // R20
                     end else begin
                        state <= GAT_LOW_SP; // R21
                        latch_cleared <= 1'b0;
                     end
                  end
               end
               GAT_LOW_SP: begin
                  if (press_set) begin
                     state <= GAT_LOW_DIR; // R16
                  end
               end
               GAT_LOW_DIR: begin
                  if (press_set) begin
                     state <= GAT_HIGH_SP; // R16
                  end
               end
               GAT_HIGH_SP: begin
                  if (press_set) begin
                     state <= GAT_HIGH_DIR; // R16
                  end
               end
               GAT_HIGH_DIR: begin
                  if (press_set) begin
                     if (RADIO_FITTED) begin
                        state <= GAT_RADIO; // R16
                     end else begin
                        state <= GAT_NORMAL;
                        timer <= 34'(HOLDOFF_CYC); // R13
                     end
                  end
               end
               GAT_RADIO: begin
                  if (press_set) begin
                     state <= GAT_NORMAL; // R18
                     timer <= 34'(HOLDOFF_CYC); // R13
                  end
               end
               default: state <= GAT_NORMAL;
            endcase
         end
      end
   end

   function automatic logic alarm_latched_any();
      alarm_latched_any = (alarm[0] & cfg[0].latching) | (alarm[1] & cfg[1].latching);
   endfunction

   // Settings: keys in the menu, or software over the bus.
   always_ff @(posedge aclk) begin
      if (!aresetn || (clk_en && factory_req)) begin
         cfg[0] <= '{sp: LOW_DEF, rising: LOW_DIR_DEF, latching: 1'b0}; // R4 R7 R8
         cfg[1] <= '{sp: HIGH_DEF, rising: 1'b1, latching: 1'b0}; // R4 R7 R8
         radio_addr <= `GAT_ADDR_DEF; // R17
      end else if (clk_en) begin
         case (state)
            GAT_LOW_SP, GAT_HIGH_SP: begin
               if (press_inc && cfg[state == GAT_HIGH_SP].sp < SP_MAX) begin
                  cfg[state == GAT_HIGH_SP].sp <= cfg[state == GAT_HIGH_SP].sp + 16'h1; // R14
               end else if (press_dec && cfg[state == GAT_HIGH_SP].sp != 16'h0) begin
                  cfg[state == GAT_HIGH_SP].sp <= cfg[state == GAT_HIGH_SP].sp - 16'h1; // R14
               end
            end
            GAT_LOW_DIR, GAT_HIGH_DIR: begin
               if (press_inc) begin
                  cfg[state == GAT_HIGH_DIR].rising <= 1'b1; // R15 R6
               end else if (press_dec) begin
                  cfg[state == GAT_HIGH_DIR].rising <= 1'b0; // R15 R6
               end
            end
            GAT_RADIO: begin
               if (press_inc && radio_addr != `GAT_ADDR_MAX) begin
                  radio_addr <= radio_addr + 8'h1; // R18 R17
               end else if (press_dec && radio_addr != `GAT_ADDR_MIN) begin
                  radio_addr <= radio_addr - 8'h1; // R18 R17
               end
            end
            default: begin
               if (wr_go && w_strb[0]) begin
                  if (aw_addr == `GAT_REG_CTRL) begin
                     cfg[0].latching <= w_data[`GAT_CTRL_LOW_LATCH]; // R25
                     cfg[1].latching <= w_data[`GAT_CTRL_HIGH_LATCH]; // R25
                     cfg[0].rising <= w_data[`GAT_CTRL_LOW_DIR];
                     cfg[1].rising <= w_data[`GAT_CTRL_HIGH_DIR];
                  end else if (aw_addr == `GAT_REG_LOW_SP) begin
                     cfg[0].sp <= clamp_sp(w_data[15:0]);
                  end else if (aw_addr == `GAT_REG_HIGH_SP) begin
                     cfg[1].sp <= clamp_sp(w_data[15:0]);
                  end else if (aw_addr == `GAT_REG_ADDR && w_data[7:0] != 8'h00) begin
                     radio_addr <= w_data[7:0]; // R17
                  end
               end
            end
         endcase
      end
   end

   // One generate loop covers both alarm channels; channel 0 is low, 1 is high.
   wire hold_off = ~menu_idle | (timer != 34'h0) | unit_off; // R13
   for (genvar c = 0; c < 2; c++) begin : g_chan // R1 R2
      // Each channel owns its flop, so no two processes write one vector.
      logic alarm_q;
      wire [15:0] band = 16'((32'(cfg[c].sp) * `GAT_BAND_PCT) / 100);
      wire [16:0] up_rel = {1'b0, cfg[c].sp} + {1'b0, band};
      wire trip = cfg[c].rising ? (rd_s2 >= cfg[c].sp) : (rd_s2 <= cfg[c].sp); // R9 R10 R24
      wire rel = cfg[c].rising ? ({1'b0, rd_s2} + {1'b0, band} <= {1'b0, cfg[c].sp})
                               : ({1'b0, rd_s2} >= up_rel); // R11 R24
      wire clear_ok = cfg[c].rising ? (rd_s2 < cfg[c].sp) : (rd_s2 > cfg[c].sp);
      assign alarm[c] = alarm_q;
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            alarm_q <= 1'b0;
         end else if (clk_en) begin
            if (hold_off) begin
               alarm_q <= alarm_q & cfg[c].latching & ~unit_off;
            end else if (trip) begin
               alarm_q <= 1'b1;
            end else if (!cfg[c].latching && rel) begin
               alarm_q <= 1'b0; // R11 R25
            end else if (cfg[c].latching && press_set && !latch_cleared && clear_ok) begin
               alarm_q <= 1'b0; // R19 R20
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         led_low <= 1'b0;
         led_high <= 1'b0;
         relay_low <= 1'b0;
         relay_high <= 1'b0;
         in_menu <= 1'b0;
         warming <= 1'b1;
      end else if (clk_en) begin
         led_low <= alarm[0]; // R9
         led_high <= alarm[1]; // R10
         relay_low <= alarm[0] & RELAYS_FITTED; // R12
         relay_high <= alarm[1] & RELAYS_FITTED; // R12
         in_menu <= ~menu_idle;
         warming <= (state == GAT_WARMUP);
      end
   end

   // AXI-Lite write path: address and data taken in either order.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `GAT_RESP_OKAY;
         factory_req <= 1'b0;
      end else if (clk_en) begin
         factory_req <= 1'b0;
         s_axi_awready <= ~aw_full & ~(s_axi_awvalid & s_axi_awready);
         s_axi_wready <= ~w_full & ~(s_axi_wvalid & s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr == `GAT_REG_CTRL) begin
               s_axi_bresp <= `GAT_RESP_OKAY;
               factory_req <= w_strb[0] & w_data[`GAT_CTRL_FACTORY];
            end else if (aw_addr == `GAT_REG_LOW_SP || aw_addr == `GAT_REG_HIGH_SP) begin
               s_axi_bresp <= `GAT_RESP_OKAY;
            end else if (aw_addr == `GAT_REG_ADDR || aw_addr == `GAT_REG_STATUS) begin
               s_axi_bresp <= `GAT_RESP_OKAY;
            end else if (aw_addr == `GAT_REG_READING) begin
               s_axi_bresp <= `GAT_RESP_OKAY;
            end else begin
               s_axi_bresp <= `GAT_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI-Lite read path.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `GAT_RESP_OKAY;
      end else if (clk_en) begin
         s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `GAT_RESP_OKAY;
            if (s_axi_araddr[7:2] == `GAT_REG_CTRL >> 2) begin
               s_axi_rdata <= {28'h0, cfg[1].rising, cfg[0].rising,
                               cfg[1].latching, cfg[0].latching};
            end else if (s_axi_araddr[7:2] == `GAT_REG_LOW_SP >> 2) begin
               s_axi_rdata <= {16'h0, cfg[0].sp};
            end else if (s_axi_araddr[7:2] == `GAT_REG_HIGH_SP >> 2) begin
               s_axi_rdata <= {16'h0, cfg[1].sp};
            end else if (s_axi_araddr[7:2] == `GAT_REG_STATUS >> 2) begin
               s_axi_rdata <= {22'h0, state, unit_off, alarm[1], alarm[0]};
            end else if (s_axi_araddr[7:2] == `GAT_REG_ADDR >> 2) begin
               s_axi_rdata <= {24'h0, radio_addr};
            end else if (s_axi_araddr[7:2] == `GAT_REG_READING >> 2) begin
               s_axi_rdata <= {16'h0, rd_s2};
            end else begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= `GAT_RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // gat_alarm

// *** tb/gat_alarm_checker.sv ***
module gat_alarm_checker
   import gat_pkg::*;
#(
   parameter int unsigned OFF_HOLD_CYC = 20,
   parameter bit RELAYS_FITTED = 1'b1
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Panel keys
   input wire gat_keys_t keys,
   // Watched outputs
   input wire logic led_low,
   input wire logic led_high,
   input wire logic relay_low,
   input wire logic relay_high,
   input wire logic unit_off,
   input wire logic in_menu,
   input wire logic warming,
   input wire logic [7:0] radio_addr
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   logic dec_q;
   logic [7:0] dec_run;
   logic [3:0] set_age;

   // The run length is kept after release, since the synchroniser delays the off decision.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dec_q <= 1'b0;
         dec_run <= 8'h00;
      end else begin
         dec_q <= keys.dec;
         if (keys.dec && !dec_q) begin
            dec_run <= 8'h01;
         end else if (keys.dec && dec_run != 8'hFF) begin
            dec_run <= dec_run + 8'h01;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         set_age <= 4'hF;
      end else if (keys.set) begin
         set_age <= 4'h0;
      end else if (set_age != 4'hF) begin
         set_age <= set_age + 4'h1;
      end
   end

   AST_RELAY_LOW: assert property (relay_low == (led_low & RELAYS_FITTED))
      else $error("Relay one differs from the low alarm.");
   AST_RELAY_HIGH: assert property (relay_high == (led_high & RELAYS_FITTED))
      else $error("Relay two differs from the high alarm.");
   AST_ADDR_RANGE: assert property (radio_addr != 8'h00)
      else $error("Radio address left its range.");
   AST_MENU_QUIET: assert property (in_menu |-> !$rose(led_low) && !$rose(led_high))
      else $error("Alarm raised while the menu is open.");
   AST_HOLDOFF: assert property ($fell(in_menu) |=> (!$rose(led_low) && !$rose(led_high)) [*8])
      else $error("Alarm raised right after menu exit.");
   AST_MENU_OPEN: assert property ($rose(in_menu) |-> set_age <= 4'h6)
      else $error("Menu opened without a settings press.");
   AST_MENU_CLOSE: assert property ($fell(in_menu) |-> set_age <= 4'h6)
      else $error("Menu closed without a settings press.");
   AST_OFF_ENTRY: assert property ($rose(unit_off) |-> dec_run >= OFF_HOLD_CYC - 1)
      else $error("Unit turned off without a long decrement hold.");
   AST_WAKE: assert property ($fell(unit_off) |-> ##[0:3] warming)
      else $error("Wake from off skipped the warm-up.");
endmodule // gat_alarm_checker

bind gat_alarm gat_alarm_checker #(
   .OFF_HOLD_CYC(OFF_HOLD_CYC),
   .RELAYS_FITTED(RELAYS_FITTED)
) gat_alarm_checker_i (
   .aclk(aclk),
   .aresetn(aresetn),
   .keys(keys),
   .led_low(led_low),
   .led_high(led_high),
   .relay_low(relay_low),
   .relay_high(relay_high),
   .unit_off(unit_off),
   .in_menu(in_menu),
   .warming(warming),
   .radio_addr(radio_addr)
);

// *** tb/gat_panel.sv ***
module gat_panel
   import gat_pkg::*;
(
   // Clock
   input wire logic aclk,
   // Operator keys and sensor reading
   output gat_keys_t keys,
   output logic [15:0] reading
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      keys = '0;
      reading = 16'h0000;
   end

   // Keys are plain levels with no pull, so a released key reads low.
   task automatic press(input gat_keys_t k, input int n);
      keys <= k;
      repeat (n) @(posedge aclk);
      keys <= '0;
      repeat (8) @(posedge aclk);
   endtask

   task automatic set_reading(input logic [15:0] v);
      reading <= v;
   endtask
endmodule // gat_panel

// *** tb/testbench.sv ***
module testbench
   import gat_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam gat_keys_t k_inc = gat_keys_t'(3'b100);
   localparam gat_keys_t k_dec = gat_keys_t'(3'b010);
   localparam gat_keys_t k_set = gat_keys_t'(3'b001);

   logic aclk;
   logic aresetn;
   logic clk_en;
   gat_keys_t keys;
   logic [15:0] reading;
   logic led_low, led_high, relay_low, relay_high, unit_off, in_menu, warming;
   logic [7:0] radio_addr;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int fail_count = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic [1:0] rr;

   gat_alarm #(.HOLDOFF_CYC(50), .WARMUP_CYC(50), .OFF_HOLD_CYC(20)) gat_alarm_i (
      .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .reading(reading), .keys(keys),
      .led_low(led_low), .led_high(led_high), .relay_low(relay_low),
      .relay_high(relay_high), .unit_off(unit_off), .in_menu(in_menu),
      .warming(warming), .radio_addr(radio_addr),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   gat_panel gat_panel_i (.aclk(aclk), .keys(keys), .reading(reading));

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   task automatic results();
      $display("Checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // The ceiling is over thirty times the expected run, so only a real hang reaches it.
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         results();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic chk1(input logic seen, input logic exp);
      check({31'h0, seen}, {31'h0, exp});
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic a_ok, w_ok;
      a_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(a_ok && w_ok)) begin
         @(posedge aclk);
         if (!a_ok && s_axi_awready) begin
            a_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
      // One idle edge, so a following call never raises a ready in the same step.
      @(posedge aclk);
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic step(input logic [15:0] r, input logic el, input logic eh);
      gat_panel_i.set_reading(r);
      idle(8);
      chk1(led_low, el);
      chk1(relay_low, el);
      chk1(led_high, eh);
      chk1(relay_high, eh);
   endtask

   initial begin
      aresetn = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      clk_en = 1'b1;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      idle(4);
      check({24'h0, radio_addr}, 32'h1);
      rd_reg(8'h04, rd, rr);
      check(rd, 32'h64);
      rd_reg(8'h08, rd, rr);
      check(rd, 32'h96);
      rd_reg(8'h00, rd, rr);
      check(rd & 32'hC, 32'hC);
      rd_reg(8'h20, rd, rr);
      check({30'h0, rr}, 32'h2);
      wr(8'h20, 32'h0);
      check({30'h0, rr}, 32'h2);
      wr(8'h08, 32'h3E8);
      rd_reg(8'h08, rd, rr);
      check(rd, 32'h258);
      wr(8'h08, 32'h96);
      $display("Test defaults and limits done");
      wr(8'h00, 32'hC);
      step(16'h0063, 1'b0, 1'b0);
      step(16'h0064, 1'b1, 1'b0);
      step(16'h0096, 1'b1, 1'b1);
      step(16'h0088, 1'b1, 1'b1);
      step(16'h0087, 1'b1, 1'b0);
      step(16'h005B, 1'b1, 1'b0);
      step(16'h005A, 1'b0, 1'b0);
      wr(8'h00, 32'h8);
      step(16'h0078, 1'b0, 1'b0);
      step(16'h0064, 1'b1, 1'b0);
      step(16'h006D, 1'b1, 1'b0);
      step(16'h006E, 1'b0, 1'b0);
      $display("Test rising and falling alarms done");
      wr(8'h00, 32'hD);
      step(16'h0064, 1'b1, 1'b0);
      step(16'h0000, 1'b1, 1'b0);
      gat_panel_i.press(k_set, 4);
      chk1(led_low, 1'b0);
      chk1(in_menu, 1'b0);
      gat_panel_i.press(k_set, 4);
      chk1(in_menu, 1'b1);
      $display("Test latched alarm reset done");
      gat_panel_i.press(k_inc, 4);
      gat_panel_i.press(k_dec, 4);
      gat_panel_i.press(k_set, 4);
      gat_panel_i.press(k_dec, 4);
      gat_panel_i.press(k_set, 4);
      gat_panel_i.press(k_inc, 4);
      gat_panel_i.press(k_set, 4);
      gat_panel_i.press(k_inc, 4);
      gat_panel_i.press(k_set, 4);
      chk1(in_menu, 1'b1);
      gat_panel_i.press(k_dec, 4);
      check({24'h0, radio_addr}, 32'h1);
      gat_panel_i.press(k_inc, 4);
      check({24'h0, radio_addr}, 32'h2);
      gat_panel_i.press(k_set, 4);
      chk1(in_menu, 1'b0);
      step(16'h00C8, 1'b0, 1'b0);
      idle(50);
      chk1(led_high, 1'b1);
      rd_reg(8'h00, rd, rr);
      check(rd & 32'hC, 32'h8);
      rd_reg(8'h04, rd, rr);
      check(rd, 32'h64);
      rd_reg(8'h08, rd, rr);
      check(rd, 32'h97);
      $display("Test menu and hold-off done");
      wr(8'h00, 32'h10);
      rd_reg(8'h08, rd, rr);
      check(rd, 32'h96);
      check({24'h0, radio_addr}, 32'h1);
      clk_en <= 1'b0;
      gat_panel_i.set_reading(16'h0080);
      idle(8);
      chk1(led_high, 1'b1);
      clk_en <= 1'b1;
      idle(8);
      chk1(led_high, 1'b0);
      $display("Test factory defaults and freeze done");
      gat_panel_i.press(k_dec, 30);
      chk1(unit_off, 1'b1);
      idle(20);
      chk1(unit_off, 1'b1);
      gat_panel_i.press(k_inc, 4);
      chk1(unit_off, 1'b0);
      chk1(warming, 1'b1);
      idle(60);
      chk1(warming, 1'b0);
      $display("Test off and restart done");
      results();
   end
endmodule // testbench
